// ---- dac_cmd_pkg.sv ----
// constants for the octal converter write command decoder
// assumes a frame assembler upstream delivers whole 24-bit write frames
package dac_cmd_pkg;
  // ==========================================================================
  // frame layout
  localparam int FRAME_W       = 24;
  localparam int CMD_HI        = 23;
  localparam int CMD_LO        = 20;
  localparam int CHAN_HI       = 19;
  localparam int CHAN_LO       = 16;
  localparam int DATA_HI       = 15;
  localparam int DATA_LO       = 4;
  localparam int NUM_CHAN      = 8;
  localparam int DATA_W        = 12;
  // ==========================================================================
  // command and channel codes
  localparam logic [3:0] CMD_LOAD_INPUT  = 4'h0;
  localparam logic [3:0] CMD_UPDATE_DAC  = 4'h1;
  localparam logic [3:0] CMD_LOAD_UPDATE = 4'h3;
  localparam logic [3:0] CHAN_ALL        = 4'hf;
  localparam logic [11:0] DATA_RESET     = 12'h000;
endpackage : dac_cmd_pkg

// ---- dac_cmd_if.sv ----
// interface carrying decoded register strobes from decoder to register bank
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface dac_cmd_if;
  logic [7:0]  load_input;  // per-channel input register load
  logic [7:0]  load_dac;    // per-channel dac register load
  logic        from_frame;  // dac takes frame data, not input register
  logic [11:0] data;
  modport dec (output load_input, output load_dac, output from_frame, output data);
  modport bank (input load_input, input load_dac, input from_frame, input data);
endinterface : dac_cmd_if
`default_nettype wire

// ---- dac_reg_bank.sv ----
// eight pairs of input and dac registers
// assumes strobes from the decoder on the same clock
`timescale 1ns/1ns
`default_nettype none
module dac_reg_bank
  import dac_cmd_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  dac_cmd_if.bank                       cmd,
  output logic [NUM_CHAN*DATA_W-1:0]    o_input_regs,
  output logic [NUM_CHAN*DATA_W-1:0]    o_dac_regs
);
  logic [NUM_CHAN*DATA_W-1:0] in_q, in_d, dac_q, dac_d;

  // ==========================================================================
  // next values per channel
  always_comb begin
    in_d  = in_q;
    dac_d = dac_q;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (cmd.load_input[i]) begin
        in_d[i*DATA_W +: DATA_W] = cmd.data;
      end
      if (cmd.load_dac[i]) begin
        dac_d[i*DATA_W +: DATA_W] = cmd.from_frame ? cmd.data : in_q[i*DATA_W +: DATA_W];
      end
    end
  end

  // register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      in_q  <= {NUM_CHAN{DATA_RESET}};
      dac_q <= {NUM_CHAN{DATA_RESET}};
    end else begin
      in_q  <= in_d;
      dac_q <= dac_d;
    end
  end

  assign o_input_regs = in_q;
  assign o_dac_regs   = dac_q;
endmodule : dac_reg_bank
`default_nettype wire

// ---- octal_dac_write_command_decoder.sv ----
// write command decoder for an eight-channel converter
// assumes i_frame_valid pulses once per complete 24-bit write frame,
// produced by same-clock serial framing logic
// register bank shares the same clock and synchronous reset
// every output comes straight from a flip-flop
// Functional notes
// - cmd 0000, channel 0-7: load that input register only from frame data
// - cmd 0000, channel 1111: load all eight input registers
// - cmd 0000/0001, top channel bit set, not 1111: do nothing
// - cmd 0001, channel 0-7: copy input register to dac register
// - cmd 0001, channel 1111: copy all input registers to dac registers
// - cmd 0011, channel: load input and dac register together
// - data 11:4 in upper byte, 3:0 in lower byte top; low nibble ignored
// - channel codes 0000 and 0001 select channels A and B
`timescale 1ns/1ns
`default_nettype none
module octal_dac_write_command_decoder
  import dac_cmd_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_frame_valid,
  input  wire logic [FRAME_W-1:0]       i_frame,
  output logic                          o_frame_accepted,
  output logic                          o_frame_acted,
  output logic [NUM_CHAN*DATA_W-1:0]    o_input_regs,
  output logic [NUM_CHAN*DATA_W-1:0]    o_dac_regs
);
  dac_cmd_if strobes ();

  // ==========================================================================
  // signals
  // frame fields under their own names
  logic        command_bit_three;
  logic        command_bit_two;
  logic        command_bit_one;
  logic        command_bit_zero;
  logic        channel_select_bit_three;
  logic        channel_select_bit_two;
  logic        channel_select_bit_one;
  logic        channel_select_bit_zero;
  logic [7:0]  upper_data_byte;
  logic [7:0]  lower_data_byte;
  logic [3:0]  command_nibble;
  logic [3:0]  channel_nibble;
  logic [11:0] frame_data;

  // command classes and channel decode
  logic        is_load_input;
  logic        is_update_dac;
  logic        is_load_update;
  logic        is_unsupported;
  logic        chan_all;
  logic        chan_invalid;
  logic [7:0]  one_hot_chan;
  logic [7:0]  chan_mask;

  // strobe state
  logic [7:0]  ld_in_d;
  logic [7:0]  ld_in_q;
  logic [7:0]  ld_dac_d;
  logic [7:0]  ld_dac_q;
  logic        from_frame_d;
  logic        from_frame_q;

  // data state
  logic [11:0] data_d;
  logic [11:0] data_q;

  // status pulse state
  logic        acc_d;
  logic        acc_q;
  logic        act_d;
  logic        act_q;

  // ==========================================================================
  // field extraction
  // command bits in the upper nibble, channel bits below them
  assign command_bit_three        = i_frame[CMD_HI];
  assign command_bit_two          = i_frame[CMD_LO+2];
  assign command_bit_one          = i_frame[CMD_LO+1];
  assign command_bit_zero         = i_frame[CMD_LO];
  assign channel_select_bit_three = i_frame[CHAN_HI];
  assign channel_select_bit_two   = i_frame[CHAN_LO+2];
  assign channel_select_bit_one   = i_frame[CHAN_LO+1];
  assign channel_select_bit_zero  = i_frame[CHAN_LO];

  // the two data bytes as the host sends them
  assign upper_data_byte = i_frame[DATA_HI -: 8];
  assign lower_data_byte = i_frame[DATA_HI-8 -: 8];

  // reassembled fields
  assign command_nibble = {command_bit_three, command_bit_two,
                           command_bit_one, command_bit_zero};
  assign channel_nibble = {channel_select_bit_three, channel_select_bit_two,
                           channel_select_bit_one, channel_select_bit_zero};
  // upper byte gives 11:4, top of lower byte gives 3:0, rest ignored
  assign frame_data     = {upper_data_byte, lower_data_byte[7:4]};

  // ==========================================================================
  // command classes
  always_comb begin
    is_load_input  = 1'b0;
    is_update_dac  = 1'b0;
    is_load_update = 1'b0;
    is_unsupported = 1'b0;
    unique case (command_nibble)
      CMD_LOAD_INPUT:  is_load_input  = 1'b1;
      CMD_UPDATE_DAC:  is_update_dac  = 1'b1;
      CMD_LOAD_UPDATE: is_load_update = 1'b1;
      default:         is_unsupported = 1'b1;
    endcase
  end

  // ==========================================================================
  // channel decode
  // codes 0 to 7 pick channels A to H
  always_comb begin
    one_hot_chan = 8'h00;
    unique case ({channel_select_bit_two, channel_select_bit_one, channel_select_bit_zero})
      3'h0: one_hot_chan = 8'h01; // channel A
      3'h1: one_hot_chan = 8'h02; // channel B
      3'h2: one_hot_chan = 8'h04;
      3'h3: one_hot_chan = 8'h08;
      3'h4: one_hot_chan = 8'h10;
      3'h5: one_hot_chan = 8'h20;
      3'h6: one_hot_chan = 8'h40;
      3'h7: one_hot_chan = 8'h80;
    endcase
  end

  // top channel bit set: only 1111 selects, the rest does nothing
  assign chan_all     = (channel_nibble == CHAN_ALL);
  assign chan_invalid = channel_select_bit_three & ~chan_all;
  assign chan_mask    = chan_invalid ? 8'h00 : (chan_all ? 8'hff : one_hot_chan);

  // ==========================================================================
  // strobes per frame
  always_comb begin
    ld_in_d      = 8'h00;
    ld_dac_d     = 8'h00;
    from_frame_d = 1'b0;
    if (i_frame_valid) begin
      if (is_load_input) begin
        ld_in_d = chan_mask;
      end
      if (is_update_dac) begin
        ld_dac_d = chan_mask;
      end
      if (is_load_update) begin
        ld_in_d      = chan_mask;
        ld_dac_d     = chan_mask;
        from_frame_d = 1'b1;
      end
    end
  end

  // register strobes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ld_in_q      <= 8'h00;
      ld_dac_q     <= 8'h00;
      from_frame_q <= 1'b0;
    end else begin
      ld_in_q      <= ld_in_d;
      ld_dac_q     <= ld_dac_d;
      from_frame_q <= from_frame_d;
    end
  end

  // ==========================================================================
  // data held for the bank
  always_comb begin
    data_d = data_q;
    if (i_frame_valid) begin
      data_d = frame_data;
    end
  end

  // register data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      data_q <= DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // ==========================================================================
  // status pulses
  always_comb begin
    acc_d = i_frame_valid;
    act_d = i_frame_valid & ~is_unsupported & (|chan_mask);
  end

  // register pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      acc_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      act_q <= act_d;
    end
  end

  assign strobes.load_input = ld_in_q;
  assign strobes.load_dac   = ld_dac_q;
  assign strobes.from_frame = from_frame_q;
  assign strobes.data       = data_q;
  assign o_frame_accepted   = acc_q;
  assign o_frame_acted      = act_q;

  // ==========================================================================
  // register bank
  dac_reg_bank u_bank (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .cmd          (strobes),
    .o_input_regs (o_input_regs),
    .o_dac_regs   (o_dac_regs)
  );
endmodule : octal_dac_write_command_decoder
`default_nettype wire

// ---- dac_dec_checker.sv ----
// port checker for the write command decoder
// assumes binding onto the decoder top
`timescale 1ns/1ns
`default_nettype none
module dac_dec_checker
  import dac_cmd_pkg::*;
(
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst,
  input wire logic                  i_frame_valid,
  input wire logic [FRAME_W-1:0]    i_frame,
  input wire logic                  o_frame_accepted,
  input wire logic                  o_frame_acted,
  input wire logic [95:0]           o_input_regs,
  input wire logic [95:0]           o_dac_regs
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // command and channel fields
  wire logic [3:0] cm = i_frame[23:20];
  wire logic [3:0] ch = i_frame[19:16];
  property p_acc; o_frame_accepted == $past(i_frame_valid); endproperty
  a_acc: assert property (p_acc) else $error("accept pulse wrong");
  property p_bad; i_frame_valid && cm < 4'h2 && ch[3] && ch != 4'hf |=> !o_frame_acted; endproperty
  a_bad: assert property (p_bad) else $error("bad channel acted");
  property p_unk; i_frame_valid && cm != 4'h0 && cm != 4'h1 && cm != 4'h3 |=> !o_frame_acted;
  endproperty
  a_unk: assert property (p_unk) else $error("unknown command acted");
  property p_bc; i_frame_valid && cm == 4'h0 && ch == 4'hf |=> o_frame_acted; endproperty
  a_bc: assert property (p_bc) else $error("broadcast load idle");
  property p_ld; i_frame_valid && cm == 4'h0 && !ch[3] && !$past(i_frame_valid) |-> ##2
    $stable(o_dac_regs) && o_input_regs[12*$past(ch[2:0],2) +: 12] == $past(i_frame[15:4],2);
  endproperty
  a_ld: assert property (p_ld) else $error("load wrong");
  property p_cp; i_frame_valid && cm == 4'h1 && ch == 4'hf ##1 !i_frame_valid |=>
    o_dac_regs == o_input_regs; endproperty
  a_cp: assert property (p_cp) else $error("copy all wrong");
  property p_one; i_frame_valid && cm == 4'h1 && !ch[3] ##1 !i_frame_valid |=>
    o_dac_regs[12*$past(ch[2:0],2) +: 12] == o_input_regs[12*$past(ch[2:0],2) +: 12];
  endproperty
  a_one: assert property (p_one) else $error("copy one wrong");
  property p_both; i_frame_valid && cm == 4'h3 && !ch[3] |-> ##2
    o_dac_regs[12*$past(ch[2:0],2) +: 12] == $past(i_frame[15:4],2); endproperty
  a_both: assert property (p_both) else $error("load update wrong");
endmodule : dac_dec_checker
bind octal_dac_write_command_decoder dac_dec_checker dac_dec_checker_i (.i_ref_clk, .i_rst,
  .i_frame_valid, .i_frame, .o_frame_accepted, .o_frame_acted, .o_input_regs, .o_dac_regs);
`default_nettype wire

// ---- frame_host.sv ----
// host model handing whole write frames to the decoder
// assumes the bench calls send from its main sequence
`timescale 1ns/1ns
`default_nettype none
module frame_host (
  input  wire logic        i_ref_clk,
  output logic             o_frame_valid,
  output logic [23:0]      o_frame
);
  initial begin
    o_frame_valid = 1'b0;
    o_frame       = 24'h000000;
  end
  // command, channel, upper then lower data byte
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [11:0] d);
    @(negedge i_ref_clk);
    o_frame_valid = 1'b1;
    o_frame       = {c, a, d[11:4], d[3:0], 4'h5};
    @(negedge i_ref_clk);
    o_frame_valid = 1'b0;
    o_frame       = ~o_frame; // released lines lose the value
  endtask : send
endmodule : frame_host
`default_nettype wire

// ---- octal_dac_write_command_decoder_tb_top.sv ----
// bench for the write command decoder
// assumes frame_host as the frame source
`timescale 1ns/1ns
`default_nettype none
module octal_dac_write_command_decoder_tb_top
  import dac_cmd_pkg::*;
;
  logic i_ref_clk, i_rst, fv, acc, act;
  logic [23:0] fr;
  logic [95:0] ir, dr, e_in, e_dac;
  int fail_count = 0;
  int compares = 0;
  frame_host frame_host_i (.i_ref_clk, .o_frame_valid(fv), .o_frame(fr));
  octal_dac_write_command_decoder octal_dac_write_command_decoder_i (.i_ref_clk, .i_rst,
    .i_frame_valid(fv), .i_frame(fr), .o_frame_accepted(acc), .o_frame_acted(act),
    .o_input_regs(ir), .o_dac_regs(dr));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input logic [95:0] s, input logic [95:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // one frame, judge pulses, let registers land
  task automatic go(input logic [3:0] c, a, input logic [11:0] d, input logic x);
    frame_host_i.send(c, a, d);
    check({acc, act}, {1'b1, x});
    @(negedge i_ref_clk);
  endtask : go
  task automatic regs;
    check(ir, e_in);
    check(dr, e_dac);
  endtask : regs
  task automatic t_load;
    go(4'h0, 4'h0, 12'h123, 1'b1);
    go(4'h0, 4'h7, 12'hfed, 1'b1);
    e_in[11:0] = 12'h123;
    e_in[95:84] = 12'hfed;
    regs();
  endtask : t_load
  task automatic t_copy;
    go(4'h0, 4'hf, 12'h5a5, 1'b1);
    go(4'h0, 4'h1, 12'habc, 1'b1);
    go(4'h1, 4'h1, 12'h000, 1'b1);
    e_in = {8{12'h5a5}};
    e_in[23:12] = 12'habc;
    e_dac[23:12] = 12'habc;
    regs();
    go(4'h1, 4'hf, 12'h000, 1'b1);
    e_dac = e_in;
    regs();
  endtask : t_copy
  task automatic t_bad;
    go(4'h0, 4'h9, 12'h777, 1'b0);
    go(4'h1, 4'h8, 12'h777, 1'b0);
    go(4'h7, 4'h0, 12'h777, 1'b0);
    go(4'h3, 4'ha, 12'h777, 1'b0);
    regs();
  endtask : t_bad
  task automatic t_both;
    go(4'h3, 4'h2, 12'h9c3, 1'b1);
    e_in[35:24] = 12'h9c3;
    e_dac[35:24] = 12'h9c3;
    regs();
    go(4'h3, 4'hf, 12'h48c, 1'b1);
    e_in = {8{12'h48c}};
    e_dac = {8{12'h48c}};
    regs();
  endtask : t_both
  initial begin
    e_in = '0;
    e_dac = '0;
    i_rst = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    i_rst = 1'b0;
    regs();
    t_load();
    t_copy();
    t_bad();
    t_both();
    i_rst = 1'b1;
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    e_in = '0;
    e_dac = '0;
    regs();
    report_and_stop();
  end
  // watchdog well past the twelve frames
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule : octal_dac_write_command_decoder_tb_top
`default_nettype wire
